// ### rtl/coisec_top.sv
// Operation
// - Bits 2,1,0 route update, high, low sources
// - Source enables reset to disabled
// - Delay interrupt after output-on only if enabled
// - Event control register at 15h
// - Polarity bit selects high/rising or low/falling sense
// - Optional glitch filter with selectable period
// - Enable bit for off delay after STOP
// - Writable event synchronization control bit
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module coisec_top
  import coisec_pkg::*;
#(
  parameter int DELAY_CNT = DELAY_CYCLES,
  parameter int SP_CNT_1  = SP_CYC_1,
  parameter int SP_CNT_2  = SP_CYC_2,
  parameter int SP_CNT_3  = SP_CYC_3
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire coisec_src_s irq_src,
  input  wire logic        event_input_pin,
  output logic             clock_output_pin,
  output logic             clock_output_pin_irq,
  output logic             event_detect,
  output logic             clock_output_pin_off_delay_en,
  output logic             event_sync_en,
  output logic             irq
);
  logic [7:0]  mask_r;
  logic [7:0]  evt_r;
  logic [1:0]  ists_r;
  logic [1:0]  imsk_r;
  logic [31:0] prdata_r;
  logic        wr_en;
  logic        rd_en;
  logic        known;
  logic [7:0]  wb;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign known   = (paddr == ADDR_MASK) || (paddr == ADDR_EVT_CTRL) ||
                   (paddr == ADDR_IRQ_STATUS) || (paddr == ADDR_IRQ_MASK) ||
                   (paddr == ADDR_EVT_LEVEL);
  assign pslverr = psel && penable && !known;
  assign wb      = pwdata[7:0];
  assign prdata  = prdata_r;

  // Source enables and delay enable all reset to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= MASK_RESET;
    end else if (wr_en && paddr == ADDR_MASK) begin
      mask_r <= wb & MASK_WR_BITS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r <= EVT_RESET;
    end else if (wr_en && paddr == ADDR_EVT_CTRL) begin
      evt_r <= wb & EVT_WR_BITS;
    end
  end

  assign clock_output_pin_off_delay_en = evt_r[EVT_OFFDLY_BIT];
  assign event_sync_en       = evt_r[EVT_SYNC_BIT];

  // Pin synchroniser: a change counts when stages two and three agree.
  logic [2:0] pin_sync_r;
  logic       pin_lvl_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 3'b000;
      pin_lvl_r  <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], event_input_pin};
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_lvl_r <= pin_sync_r[2];
      end
    end
  end

  // Glitch filter: the level must hold across two sample ticks.
  logic [1:0]  period;
  logic [31:0] sp_cnt_r;
  logic [31:0] sp_max;
  logic        tick;
  logic        samp_r;
  logic        filt_r;
  assign period = evt_r[EVT_PERIOD_LO +: 2];
  always_comb begin
    unique case (period)
      2'd1:    sp_max = 32'(SP_CNT_1);
      2'd2:    sp_max = 32'(SP_CNT_2);
      2'd3:    sp_max = 32'(SP_CNT_3);
      default: sp_max = 32'd0;
    endcase
  end
  assign tick = (sp_cnt_r + 32'd1 >= sp_max);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_cnt_r <= 32'd0;
      samp_r   <= 1'b0;
      filt_r   <= 1'b0;
    end else if (period == 2'd0) begin
      sp_cnt_r <= 32'd0;
      samp_r   <= pin_lvl_r;
      filt_r   <= pin_lvl_r;
    end else if (tick) begin
      sp_cnt_r <= 32'd0;
      samp_r   <= pin_lvl_r;
      if (samp_r == pin_lvl_r) begin
        filt_r <= pin_lvl_r;
      end
    end else begin
      sp_cnt_r <= sp_cnt_r + 32'd1;
    end
  end

  // Polarity: 1 senses high level / rising edge, 0 low level / falling.
  logic filt_d_r;
  logic pol_lvl;
  logic edge_hit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_d_r <= 1'b0;
    end else begin
      filt_d_r <= filt_r;
    end
  end
  assign pol_lvl      = evt_r[EVT_POL_BIT] ? filt_r : !filt_r;
  assign edge_hit     = evt_r[EVT_POL_BIT] ? (filt_r && !filt_d_r)
                                           : (!filt_r && filt_d_r);
  assign event_detect = pol_lvl;

  // Source selection onto the clock output.
  logic src_any;
  assign src_any = (mask_r[MASK_UPDATE_BIT] && irq_src.time_update) ||
                   (mask_r[MASK_THIGH_BIT]  && irq_src.temp_high)   ||
                   (mask_r[MASK_TLOW_BIT]   && irq_src.temp_low);

  coisec_co_e  co_r;
  logic [31:0] dly_r;
  logic        clock_output_pin_r;
  logic        cirq_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      co_r     <= CO_IDLE;
      dly_r    <= 32'd0;
      clock_output_pin_r <= 1'b0;
      cirq_r   <= 1'b0;
    end else begin
      unique case (co_r)
        CO_IDLE: begin
          cirq_r <= 1'b0;
          if (src_any) begin
            clock_output_pin_r <= 1'b1;
            dly_r    <= 32'd0;
            if (mask_r[MASK_DELAY_BIT]) begin
              co_r <= CO_WAIT;
            end else begin
              co_r   <= CO_FIRE;
              cirq_r <= 1'b1;
            end
          end else begin
            clock_output_pin_r <= 1'b0;
          end
        end
        CO_WAIT: begin
          if (!src_any) begin
            co_r     <= CO_IDLE;
            clock_output_pin_r <= 1'b0;
          end else if (dly_r + 32'd1 >= 32'(DELAY_CNT)) begin
            co_r   <= CO_FIRE;
            cirq_r <= 1'b1;
          end else begin
            dly_r <= dly_r + 32'd1;
          end
        end
        CO_FIRE: begin
          if (!src_any) begin
            co_r     <= CO_IDLE;
            clock_output_pin_r <= 1'b0;
            cirq_r   <= 1'b0;
          end
        end
        default: co_r <= CO_IDLE;
      endcase
    end
  end
  assign clock_output_pin = clock_output_pin_r;
  assign clock_output_pin_irq       = cirq_r;

  // Sticky status, write one to clear; a new event wins over the clear.
  logic       cirq_d_r;
  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cirq_d_r <= 1'b0;
    end else begin
      cirq_d_r <= cirq_r;
    end
  end
  assign ev_set[IRQ_CLOCK_OUTPUT_PIN_BIT] = cirq_r && !cirq_d_r;
  assign ev_set[IRQ_EVENT_BIT]  = edge_hit;
  assign ev_clr = (wr_en && paddr == ADDR_IRQ_STATUS) ? pwdata[1:0] : 2'b00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_r <= IRQ_RESET;
    end else begin
      ists_r <= (ists_r & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imsk_r <= IRQ_RESET;
    end else if (wr_en && paddr == ADDR_IRQ_MASK) begin
      imsk_r <= pwdata[1:0];
    end
  end
  assign irq = |(ists_r & imsk_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_MASK:       prdata_r <= {24'h00_0000, mask_r};
        ADDR_EVT_CTRL:   prdata_r <= {24'h00_0000, evt_r};
        ADDR_IRQ_STATUS: prdata_r <= {30'h0000_0000, ists_r};
        ADDR_IRQ_MASK:   prdata_r <= {30'h0000_0000, imsk_r};
        ADDR_EVT_LEVEL:  prdata_r <= {29'h0000_0000, clock_output_pin_r, pol_lvl, filt_r};
        default:         prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Routing, reset and delay of the clock output interrupt.
  a_src_route: assert property (@(posedge pclk) disable iff (!presetn)
    (co_r == CO_IDLE && src_any && !mask_r[MASK_DELAY_BIT]) |=> cirq_r)
    else $error("enabled source did not raise clock output interrupt");

  a_clock_output_pin_on: assert property (@(posedge pclk) disable iff (!presetn)
    (co_r == CO_IDLE && src_any) |=> clock_output_pin)
    else $error("enabled source did not switch the clock output on");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_MASK) |=> mask_r == $past(wb & MASK_WR_BITS))
    else $error("mask write lost");

  a_mask_reset: assert property (@(posedge pclk)
    $rose(presetn) |-> mask_r[2:0] == 3'b000)
    else $error("source enables not cleared by reset");

  sequence s_wait_start;
    co_r == CO_IDLE && src_any && mask_r[MASK_DELAY_BIT];
  endsequence

  a_delay_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_wait_start |=> !cirq_r[*2])
    else $error("interrupt raised before delay");

  // The delay counter must run to its end before the interrupt fires.
  a_delay_count: assert property (@(posedge pclk) disable iff (!presetn)
    (co_r == CO_WAIT && dly_r + 32'd1 < 32'(DELAY_CNT)) |=> !cirq_r)
    else $error("interrupt raised before delay count ended");

  a_state_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot(co_r))
    else $error("clock output state not one-hot");

  a_no_src_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (!src_any [*2]) |=> !cirq_r)
    else $error("indication active without source");

  a_clock_output_pin_off: assert property (@(posedge pclk) disable iff (!presetn)
    (co_r != CO_IDLE && !src_any) |=> !clock_output_pin && !clock_output_pin_irq)
    else $error("clock output stayed on without source");

  // Event control register and the bits it drives out.
  a_evt_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_EVT_CTRL) |=> evt_r == $past(wb & EVT_WR_BITS))
    else $error("event control write lost");

  a_offdly_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_EVT_CTRL) |=> clock_output_pin_off_delay_en == $past(wb[EVT_OFFDLY_BIT]))
    else $error("off delay enable not stored");

  a_sync_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_EVT_CTRL) |=> event_sync_en == $past(wb[EVT_SYNC_BIT]))
    else $error("sync bit not stored");

  // Event sensing: filtered level and edges of the selected polarity.
  a_pol_level: assert property (@(posedge pclk) disable iff (!presetn)
    event_detect == (evt_r[EVT_POL_BIT] == filt_r))
    else $error("polarity sense wrong");

  sequence s_rise_seen;
    evt_r[EVT_POL_BIT] && $rose(filt_r);
  endsequence

  sequence s_fall_seen;
    !evt_r[EVT_POL_BIT] && $fell(filt_r);
  endsequence

  a_rise_event: assert property (@(posedge pclk) disable iff (!presetn)
    s_rise_seen |=> ists_r[IRQ_EVENT_BIT])
    else $error("rising event not recorded");

  a_fall_event: assert property (@(posedge pclk) disable iff (!presetn)
    s_fall_seen |=> ists_r[IRQ_EVENT_BIT])
    else $error("falling event not recorded");

  // Synchroniser and glitch filter.
  a_sync_agree: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_sync_r[1] != pin_sync_r[2]) |=> $stable(pin_lvl_r))
    else $error("pin level moved while sync stages disagree");

  a_filter_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (period == 2'd0 && $stable(pin_lvl_r)) |=> filt_r == $past(pin_lvl_r))
    else $error("unfiltered path did not follow pin");

  a_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (period != 2'd0 && !tick) |=> $stable(filt_r))
    else $error("filtered level moved between sample ticks");

  a_filter_reject: assert property (@(posedge pclk) disable iff (!presetn)
    (period != 2'd0 && tick && samp_r != pin_lvl_r) |=> $stable(filt_r))
    else $error("filter took a level seen only once");

  // Sticky status: a new event beats a clear in the same cycle.
  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    ev_set[IRQ_CLOCK_OUTPUT_PIN_BIT] |=> ists_r[IRQ_CLOCK_OUTPUT_PIN_BIT])
    else $error("clock output event lost");

  a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_clr[IRQ_CLOCK_OUTPUT_PIN_BIT] && !ev_set[IRQ_CLOCK_OUTPUT_PIN_BIT]) |=> !ists_r[IRQ_CLOCK_OUTPUT_PIN_BIT])
    else $error("status bit not cleared by write of one");
endmodule
`default_nettype wire

// ### pkg/coisec_pkg.sv
`default_nettype none
package coisec_pkg;
  // Register indices; each byte address is four times its index.
  localparam logic [9:0]  IDX_MASK         = 10'h014;
  localparam logic [9:0]  IDX_EVT_CTRL     = 10'h015;
  localparam logic [11:0] ADDR_MASK        = {IDX_MASK, 2'b00};
  localparam logic [11:0] ADDR_EVT_CTRL    = {IDX_EVT_CTRL, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h058;
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h05C;
  localparam logic [11:0] ADDR_EVT_LEVEL   = 12'h060;

  localparam int MASK_TLOW_BIT    = 0;
  localparam int MASK_THIGH_BIT   = 1;
  localparam int MASK_UPDATE_BIT  = 2;
  localparam int MASK_DELAY_BIT   = 6;
  localparam logic [7:0] MASK_WR_BITS    = 8'h47;
  localparam logic [7:0] MASK_RESET      = 8'h00;

  localparam int EVT_SYNC_BIT     = 0;
  localparam int EVT_PERIOD_LO    = 4;
  localparam int EVT_POL_BIT      = 6;
  localparam int EVT_OFFDLY_BIT   = 7;
  localparam logic [7:0] EVT_WR_BITS     = 8'hF1;
  localparam logic [7:0] EVT_RESET       = 8'h00;

  localparam int IRQ_CLOCK_OUTPUT_PIN_BIT   = 0;
  localparam int IRQ_EVENT_BIT    = 1;
  localparam logic [1:0] IRQ_RESET       = 2'h0;

  // Interrupt delay after clock output turns on: 1/256 s.
  localparam longint DELAY_NS     = 64'd3_906_250;
  localparam longint CLK_PERIOD_NS = 64'd10;
  localparam int DELAY_CYCLES     = int'(DELAY_NS / CLK_PERIOD_NS);
  // Filter sample periods per period field, in ns.
  localparam longint SP_NS_0      = 64'd0;
  localparam longint SP_NS_1      = 64'd3_906_250;
  localparam longint SP_NS_2      = 64'd15_625_000;
  localparam longint SP_NS_3      = 64'd125_000_000;
  localparam int SP_CYC_1         = int'(SP_NS_1 / CLK_PERIOD_NS);
  localparam int SP_CYC_2         = int'(SP_NS_2 / CLK_PERIOD_NS);
  localparam int SP_CYC_3         = int'(SP_NS_3 / CLK_PERIOD_NS);

  typedef struct packed {
    logic time_update;
    logic temp_high;
    logic temp_low;
  } coisec_src_s;

  typedef enum logic [2:0] {
    CO_IDLE  = 3'b001,
    CO_WAIT  = 3'b010,
    CO_FIRE  = 3'b100
  } coisec_co_e;
endpackage
`default_nettype wire

// ### dv/coisec_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// Interrupt sources and event pin, each launched on a clock edge.
module coisec_src_model
  import coisec_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic  [2:0] src_want,
  input  wire logic        pin_want,
  input  wire logic        glitch,
  output var coisec_src_s  irq_src,
  output var logic         event_input_pin
);
  initial begin
    irq_src = '0;
    event_input_pin = 1'b0;
  end
  always @(posedge pclk) begin
    irq_src <= coisec_src_s'(src_want);
    event_input_pin <= pin_want ^ glitch;
  end
endmodule
`default_nettype wire

// ### dv/coisec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module clock_output_pin_irq_select_event_ctrl_bench import coisec_pkg::*;;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0]  src_want = 3'h0;
  logic        pin_want = 1'b0;
  logic        glitch = 1'b0;
  logic        pready, pslverr, clock_output_pin, clock_output_pin_irq, event_detect;
  logic        clock_output_pin_off_delay_en, event_sync_en, irq, event_input_pin, err;
  logic [31:0] prdata, rd;
  coisec_src_s irq_src;
  int          num_errors = 0;
  int          checks_done = 0;

  always #5 pclk = ~pclk;

  coisec_top #(.DELAY_CNT(4), .SP_CNT_1(3), .SP_CNT_2(5), .SP_CNT_3(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq_src(irq_src), .event_input_pin(event_input_pin),
    .clock_output_pin(clock_output_pin), .clock_output_pin_irq(clock_output_pin_irq),
    .event_detect(event_detect), .clock_output_pin_off_delay_en(clock_output_pin_off_delay_en),
    .event_sync_en(event_sync_en), .irq(irq));

  coisec_src_model PEER (.pclk(pclk), .src_want(src_want), .pin_want(pin_want),
    .glitch(glitch), .irq_src(irq_src), .event_input_pin(event_input_pin));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20_000) @(posedge pclk);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    cyc(3);
    presetn <= 1'b1;
    cyc(1);
    apb(ADDR_MASK, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000, "mask reset");
    apb(ADDR_EVT_CTRL, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000, "evt reset");
    apb(ADDR_MASK, 1'b1, 32'h0000_00FF);
    apb(ADDR_MASK, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0047, "mask bits");
    apb(ADDR_EVT_CTRL, 1'b1, 32'h0000_00FF);
    apb(ADDR_EVT_CTRL, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_00F1, "evt bits");
    check({clock_output_pin_off_delay_en, event_sync_en}, 2'b11, "evt outs");
    apb(ADDR_EVT_CTRL, 1'b1, 32'h0000_0001);
    check({clock_output_pin_off_delay_en, event_sync_en}, 2'b01, "sync only");
    apb(12'h0FC, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000, "unmapped data");
    check({31'h0000_0000, err}, 32'h0000_0001, "unmapped error");
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      apb(ADDR_MASK, 1'b1, 32'(1 << i));
      src_want <= 3'(~(1 << i));
      cyc(4);
      check({clock_output_pin, clock_output_pin_irq}, 2'b00, "other srcs");
      src_want <= 3'(1 << i);
      cyc(4);
      check({clock_output_pin, clock_output_pin_irq}, 2'b11, "chosen src");
      src_want <= 3'h0;
      cyc(4);
      check({clock_output_pin, clock_output_pin_irq}, 2'b00, "src drop");
    end
    apb(ADDR_MASK, 1'b1, 32'h0000_0044);
    src_want <= 3'h4;
    cyc(3);
    check({clock_output_pin, clock_output_pin_irq}, 2'b10, "irq held");
    cyc(3);
    check(clock_output_pin_irq, 1'b0, "irq not early");
    cyc(1);
    check(clock_output_pin_irq, 1'b1, "irq after delay");
    cyc(2);
    src_want <= 3'h0;
    cyc(4);
    $display("test routing done");
    apb(ADDR_IRQ_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0001, "status set");
    check(irq, 1'b0, "masked");
    apb(ADDR_IRQ_MASK, 1'b1, 32'h0000_0001);
    check(irq, 1'b1, "unmasked");
    apb(ADDR_IRQ_STATUS, 1'b1, 32'h0000_0001);
    check(irq, 1'b0, "cleared");
    apb(ADDR_IRQ_MASK, 1'b1, 32'h0000_0000);
    $display("test interrupt done");
    apb(ADDR_EVT_CTRL, 1'b1, 32'h0000_0000);
    pin_want <= 1'b1;
    cyc(8);
    apb(ADDR_EVT_LEVEL, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0001, "level high");
    check(event_detect, 1'b0, "low sense off");
    pin_want <= 1'b0;
    cyc(8);
    check(event_detect, 1'b1, "low sense on");
    apb(ADDR_IRQ_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0002, "fall event");
    apb(ADDR_IRQ_STATUS, 1'b1, 32'h0000_0002);
    apb(ADDR_EVT_CTRL, 1'b1, 32'h0000_0040);
    cyc(2);
    check(event_detect, 1'b0, "polarity");
    pin_want <= 1'b1;
    cyc(8);
    check(event_detect, 1'b1, "high sense on");
    apb(ADDR_IRQ_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0002, "rise event");
    pin_want <= 1'b0;
    // A two-cycle glitch gets through the synchroniser but must not pass the filter.
    for (int p = 1; p < 4; p++) begin
      apb(ADDR_EVT_CTRL, 1'b1, 32'(p << EVT_PERIOD_LO));
      cyc(30);
      apb(ADDR_IRQ_STATUS, 1'b1, 32'h0000_0002);
      glitch <= 1'b1;
      cyc(2);
      glitch <= 1'b0;
      cyc(30);
      apb(ADDR_IRQ_STATUS, 1'b0, 32'h0000_0000);
      check(rd, 32'h0000_0000, "glitch no event");
      apb(ADDR_EVT_LEVEL, 1'b0, 32'h0000_0000);
      check(rd, 32'h0000_0002, "glitch kept out");
      pin_want <= 1'b1;
      cyc(30);
      apb(ADDR_EVT_LEVEL, 1'b0, 32'h0000_0000);
      check(rd, 32'h0000_0001, "steady passed");
      pin_want <= 1'b0;
    end
    $display("test events done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
